//--- design/dpscb_regs.vh
// Notes on behaviour
// - Lock after four comparisons under 15 ns
// - Lock drops on one comparison over 30 ns
// - Powered-down loop holds its lock low
// - Enable low stops counters, unbiases rf input
// - Reference stage off only when both disabled
// - Power down floats pump, stops bandgap
// - Bandgap first, loop active 1 us later
// - Latched words survive power down
// - Serial load and latch work while down
// - Word is 16-bit payload plus 2 address bits
// - Latch strobe rise copies word to latch
// - Address 00,01,10,11 selects the four latches
// - Secondary reference: output select, ref count
// - Primary reference: pump control, ref count
// - Secondary feedback: main count, swallow count
// - 500 MHz variant ignores swallow top bit
// - Primary feedback split depends on variant
// - Ratio is modulus times main plus swallow
// - Pump word: two gains, two polarities
// - Output select picks one of nine sources
// - New divide value loads at counter zero
`ifndef DPSCB_REGS_VH
`define DPSCB_REGS_VH

// ----------------------------------------
// Serial word
// ----------------------------------------
`define DPSCB_WORD_W 18
`define DPSCB_ADDR_SEC_REF 2'h0
`define DPSCB_ADDR_SEC_FB 2'h1
`define DPSCB_ADDR_PRI_REF 2'h2
`define DPSCB_ADDR_PRI_FB 2'h3

// ----------------------------------------
// Payload fields
// ----------------------------------------
`define DPSCB_SEL_MSB 15
`define DPSCB_SEL_LSB 12
`define DPSCB_CNT_MSB 11
`define DPSCB_SEC_GAIN_BIT 15
`define DPSCB_PRI_GAIN_BIT 14
`define DPSCB_SEC_POL_BIT 13
`define DPSCB_PRI_POL_BIT 12
`define DPSCB_RST_WORD 16'h0000

// ----------------------------------------
// Prescaler moduli
// ----------------------------------------
`define DPSCB_MOD_32 6'h20
`define DPSCB_MOD_16 6'h10
`define DPSCB_MOD_8 6'h08

// ----------------------------------------
// Timing
// ----------------------------------------
`define DPSCB_CLK_MHZ 100
`define DPSCB_POWERUP_NS 1000
`define DPSCB_POWERUP_CYC (`DPSCB_POWERUP_NS * `DPSCB_CLK_MHZ / 1000)
`define DPSCB_LOCK_IN_NS 15
`define DPSCB_LOCK_OUT_NS 30
`define DPSCB_LOCK_IN_CYC ((`DPSCB_LOCK_IN_NS * `DPSCB_CLK_MHZ + 999) / 1000)
`define DPSCB_LOCK_OUT_CYC (`DPSCB_LOCK_OUT_NS * `DPSCB_CLK_MHZ / 1000)
`define DPSCB_LOCK_RUN 3'h4

`endif

//--- design/dpscb_loop.v
`timescale 1ns/1ns
`include "dpscb_regs.vh"

module dpscb_loop (
   input wire clk,
   input wire rst,
   input wire enable,
   input wire ref_edge,
   input wire rf_edge,
   input wire [11:0] ref_count,
   input wire [11:0] main_count,
   input wire [4:0] swallow_count,
   input wire [5:0] modulus,
   input wire polarity,
   output wire bias_on,
   output reg active,
   output reg ref_out,
   output reg fb_out,
   output reg lock,
   output reg pump_drive,
   output reg pump_oe
);

   localparam integer PU_N = `DPSCB_POWERUP_CYC - 1;
   localparam integer IN_N = `DPSCB_LOCK_IN_CYC;
   localparam integer OUT_N = `DPSCB_LOCK_OUT_CYC;
   localparam [7:0] PU_LAST = PU_N[7:0];
   localparam [7:0] IN_CYC = IN_N[7:0];
   localparam [7:0] OUT_CYC = OUT_N[7:0];

   reg [7:0] pu_cnt;
   reg [11:0] r_left;
   reg [11:0] b_left;
   reg [4:0] a_left;
   reg [5:0] p_left;
   reg ref_seen;
   reg fb_seen;
   reg [7:0] err_cnt;
   reg [2:0] good;
   wire done;
   wire [4:0] a_next;

   // ----------------------------------------
   // Power sequencing
   // ----------------------------------------
   assign bias_on = enable;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pu_cnt <= 8'h00;
         active <= 1'b0;
      end else if (!enable) begin
         pu_cnt <= 8'h00;
         active <= 1'b0;
      end else if (!active) begin
         if (pu_cnt == PU_LAST)
            active <= 1'b1;
         else
            pu_cnt <= pu_cnt + 8'h01;
      end
   end

   // ----------------------------------------
   // Dividers
   // ----------------------------------------
   assign a_next = (a_left != 5'h00) ? a_left - 5'h01 : 5'h00;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         r_left <= 12'h000;
         b_left <= 12'h000;
         a_left <= 5'h00;
         p_left <= 6'h00;
         ref_out <= 1'b0;
         fb_out <= 1'b0;
      end else begin
         ref_out <= 1'b0;
         fb_out <= 1'b0;
         if (!active) begin
            r_left <= 12'h000;
            b_left <= 12'h000;
            a_left <= 5'h00;
            p_left <= 6'h00;
         end else begin
            if (ref_edge) begin
               if (r_left <= 12'h001) begin
                  r_left <= ref_count;
                  ref_out <= 1'b1;
               end else
                  r_left <= r_left - 12'h001;
            end
            if (rf_edge) begin
               if (p_left != 6'h00)
                  p_left <= p_left - 6'h01;
               else if (b_left <= 12'h001) begin
                  b_left <= main_count;
                  a_left <= swallow_count;
                  fb_out <= 1'b1;
                  // Modulus+1 while swallows remain
                  p_left <= (swallow_count != 5'h00) ?
                     modulus : modulus - 6'h01;
               end else begin
                  b_left <= b_left - 12'h001;
                  a_left <= a_next;
                  p_left <= (a_next != 5'h00) ?
                     modulus : modulus - 6'h01;
               end
            end
         end
      end
   end

   // ----------------------------------------
   // Phase compare and lock filter
   // ----------------------------------------
   assign done = (ref_out | ref_seen) & (fb_out | fb_seen);

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ref_seen <= 1'b0;
         fb_seen <= 1'b0;
         err_cnt <= 8'h00;
         good <= 3'h0;
         lock <= 1'b0;
      end else if (!active) begin
         ref_seen <= 1'b0;
         fb_seen <= 1'b0;
         err_cnt <= 8'h00;
         good <= 3'h0;
         lock <= 1'b0;
      end else if (done) begin
         ref_seen <= 1'b0;
         fb_seen <= 1'b0;
         err_cnt <= 8'h00;
         if (err_cnt > OUT_CYC) begin
            lock <= 1'b0;
            good <= 3'h0;
         end else if (err_cnt < IN_CYC) begin
            if (good == `DPSCB_LOCK_RUN - 3'h1)
               lock <= 1'b1;
            if (good != `DPSCB_LOCK_RUN)
               good <= good + 3'h1;
         end else
            good <= 3'h0;
      end else begin
         ref_seen <= ref_seen | ref_out;
         fb_seen <= fb_seen | fb_out;
         // Saturate so a lost edge cannot wrap to small
         if ((ref_seen | fb_seen | ref_out | fb_out) &&
             err_cnt != 8'hFF)
            err_cnt <= err_cnt + 8'h01;
      end
   end

   // Pump floats unless exactly one side leads
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pump_drive <= 1'b0;
         pump_oe <= 1'b0;
      end else begin
         pump_oe <= active & (ref_seen ^ fb_seen);
         pump_drive <= ref_seen ? polarity : ~polarity;
      end
   end

endmodule

//--- design/dpscb_config_bank.v
`timescale 1ns/1ns
`include "dpscb_regs.vh"

module dpscb_config_bank #(
   parameter PRI_2G_VARIANT = 1,
   parameter SEC_500M_VARIANT = 1
) (
   input wire clk,
   input wire rst,
   input wire serial_clock,
   input wire serial_data,
   input wire latch_strobe,
   input wire reference_input,
   input wire primary_rf_input,
   input wire secondary_rf_input,
   input wire primary_pll_enable,
   input wire secondary_pll_enable,
   output reg multifunction_output,
   output wire primary_pump_output,
   output wire primary_pump_output_oe,
   output wire secondary_pump_output,
   output wire secondary_pump_output_oe,
   output wire primary_pump_gain,
   output wire secondary_pump_gain,
   output wire primary_rf_bias,
   output wire secondary_rf_bias,
   output wire reference_input_bias,
   output wire primary_bandgap_on,
   output wire secondary_bandgap_on,
   output wire primary_lock,
   output wire secondary_lock
);

   // ----------------------------------------
   // Field helpers
   // ----------------------------------------
   function [11:0] fb_main;
      input [15:0] word;
      input five_bit;
      begin
         if (five_bit)
            fb_main = {1'b0, word[15:5]};
         else
            fb_main = word[15:4];
      end
   endfunction

   function [4:0] fb_swallow;
      input [15:0] word;
      input five_bit;
      input three_bit;
      begin
         if (five_bit)
            fb_swallow = word[4:0];
         else if (three_bit)
            fb_swallow = {2'h0, word[2:0]};
         else
            fb_swallow = {1'h0, word[3:0]};
      end
   endfunction

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   localparam NPIN = 7;
   localparam I_SCK = 0;
   localparam I_SDA = 1;
   localparam I_LS = 2;
   localparam I_REF = 3;
   localparam I_PRF = 4;
   localparam I_SRF = 5;
   localparam I_PEN = 6;

   reg [NPIN-1:0] sync1;
   reg [NPIN-1:0] sync2;
   reg [NPIN-1:0] sync3;
   reg sen1;
   reg sen2;
   wire [NPIN-1:0] pins;
   wire [NPIN-1:0] rise;

   assign pins = {primary_pll_enable, secondary_rf_input,
                  primary_rf_input, reference_input,
                  latch_strobe, serial_data, serial_clock};

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1 <= 7'h00;
         sync2 <= 7'h00;
         sync3 <= 7'h00;
         sen1 <= 1'b0;
         sen2 <= 1'b0;
      end else begin
         sync1 <= pins;
         sync2 <= sync1;
         sync3 <= sync2;
         sen1 <= secondary_pll_enable;
         sen2 <= sen1;
      end
   end

   assign rise = sync2 & ~sync3;

   // ----------------------------------------
   // Shift register and latches
   // ----------------------------------------
   reg [`DPSCB_WORD_W-1:0] shift;
   reg [15:0] sec_ref_divider_word;
   reg [15:0] sec_fb_divider_word;
   reg [15:0] pri_ref_divider_word;
   reg [15:0] pri_fb_divider_word;

   // Data is delayed by the same two stages as the clock,
   // so the bit seen at the clock rise is the one sampled.
   always @(posedge clk or posedge rst) begin
      if (rst)
         shift <= 18'h00000;
      else if (rise[I_SCK])
         shift <= {shift[16:0], sync2[I_SDA]};
   end

   // No enable term here: loading works while powered down
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         sec_ref_divider_word <= `DPSCB_RST_WORD;
         sec_fb_divider_word <= `DPSCB_RST_WORD;
         pri_ref_divider_word <= `DPSCB_RST_WORD;
         pri_fb_divider_word <= `DPSCB_RST_WORD;
      end else if (rise[I_LS]) begin
         case (shift[1:0])
            `DPSCB_ADDR_SEC_REF: begin
               sec_ref_divider_word <= shift[17:2];
            end
            `DPSCB_ADDR_SEC_FB: begin
               sec_fb_divider_word <= shift[17:2];
            end
            `DPSCB_ADDR_PRI_REF: begin
               pri_ref_divider_word <= shift[17:2];
            end
            default: begin
               pri_fb_divider_word <= shift[17:2];
            end
         endcase
      end
   end

   // ----------------------------------------
   // Field decode
   // ----------------------------------------
   wire [3:0] multifunction_output_select;
   wire [3:0] pump_control_word;
   wire [11:0] secondary_ref_count;
   wire [11:0] primary_ref_count;
   wire [11:0] secondary_main_count;
   wire [11:0] primary_main_count;
   wire [4:0] secondary_swallow_count;
   wire [4:0] primary_swallow_count;
   wire primary_detector_polarity;
   wire secondary_detector_polarity;
   wire pri_five;
   wire sec_three;
   wire [5:0] pri_modulus;
   wire [5:0] sec_modulus;

   assign pri_five = (PRI_2G_VARIANT != 0);
   assign sec_three = (SEC_500M_VARIANT != 0);
   assign pri_modulus = pri_five ? `DPSCB_MOD_32 : `DPSCB_MOD_16;
   assign sec_modulus = sec_three ? `DPSCB_MOD_8 : `DPSCB_MOD_16;

   assign multifunction_output_select =
      sec_ref_divider_word[`DPSCB_SEL_MSB:`DPSCB_SEL_LSB];
   assign secondary_ref_count =
      sec_ref_divider_word[`DPSCB_CNT_MSB:0];
   assign pump_control_word =
      pri_ref_divider_word[`DPSCB_SEL_MSB:`DPSCB_SEL_LSB];
   assign primary_ref_count =
      pri_ref_divider_word[`DPSCB_CNT_MSB:0];
   assign secondary_main_count =
      fb_main(sec_fb_divider_word, 1'b0);
   assign secondary_swallow_count =
      fb_swallow(sec_fb_divider_word, 1'b0, sec_three);
   assign primary_main_count =
      fb_main(pri_fb_divider_word, pri_five);
   assign primary_swallow_count =
      fb_swallow(pri_fb_divider_word, pri_five, 1'b0);

   assign secondary_pump_gain =
      pri_ref_divider_word[`DPSCB_SEC_GAIN_BIT];
   assign primary_pump_gain =
      pri_ref_divider_word[`DPSCB_PRI_GAIN_BIT];
   assign secondary_detector_polarity =
      pri_ref_divider_word[`DPSCB_SEC_POL_BIT];
   assign primary_detector_polarity =
      pri_ref_divider_word[`DPSCB_PRI_POL_BIT];

   // ----------------------------------------
   // Loops
   // ----------------------------------------
   wire pri_active;
   wire sec_active;
   wire pri_ref_out;
   wire sec_ref_out;
   wire pri_fb_out;
   wire sec_fb_out;

   // Divider logic stops; latches above keep their words
   dpscb_loop u_primary (
      .clk(clk),
      .rst(rst),
      .enable(sync2[I_PEN]),
      .ref_edge(rise[I_REF]),
      .rf_edge(rise[I_PRF]),
      .ref_count(primary_ref_count),
      .main_count(primary_main_count),
      .swallow_count(primary_swallow_count),
      .modulus(pri_modulus),
      .polarity(primary_detector_polarity),
      .bias_on(primary_bandgap_on),
      .active(pri_active),
      .ref_out(pri_ref_out),
      .fb_out(pri_fb_out),
      .lock(primary_lock),
      .pump_drive(primary_pump_output),
      .pump_oe(primary_pump_output_oe)
   );

   dpscb_loop u_secondary (
      .clk(clk),
      .rst(rst),
      .enable(sen2),
      .ref_edge(rise[I_REF]),
      .rf_edge(rise[I_SRF]),
      .ref_count(secondary_ref_count),
      .main_count(secondary_main_count),
      .swallow_count(secondary_swallow_count),
      .modulus(sec_modulus),
      .polarity(secondary_detector_polarity),
      .bias_on(secondary_bandgap_on),
      .active(sec_active),
      .ref_out(sec_ref_out),
      .fb_out(sec_fb_out),
      .lock(secondary_lock),
      .pump_drive(secondary_pump_output),
      .pump_oe(secondary_pump_output_oe)
   );

   // ----------------------------------------
   // Power control
   // ----------------------------------------
   assign primary_rf_bias = sync2[I_PEN];
   assign secondary_rf_bias = sen2;
   assign reference_input_bias = sync2[I_PEN] | sen2;

   // ----------------------------------------
   // Multifunction output
   // ----------------------------------------
   always @(posedge clk or posedge rst) begin
      if (rst)
         multifunction_output <= 1'b0;
      else begin
         case (multifunction_output_select[3:1])
            3'h0: begin
               multifunction_output <= multifunction_output_select[0];
            end
            3'h1: begin
               multifunction_output <= primary_lock;
            end
            3'h2: begin
               multifunction_output <= secondary_lock;
            end
            3'h3: begin
               multifunction_output <= primary_lock & secondary_lock;
            end
            3'h4: begin
               multifunction_output <= pri_ref_out;
            end
            3'h5: begin
               multifunction_output <= sec_ref_out;
            end
            3'h6: begin
               multifunction_output <= pri_fb_out;
            end
            default: begin
               multifunction_output <= sec_fb_out;
            end
         endcase
      end
   end

endmodule

//--- tb/dpscb_checker.sv
`timescale 1ns/1ns

module dpscb_checker (
   input wire clk,
   input wire rst,
   input wire latch_strobe,
   input wire primary_pll_enable,
   input wire secondary_pll_enable,
   input wire primary_pump_output_oe,
   input wire secondary_pump_output_oe,
   input wire primary_pump_gain,
   input wire secondary_pump_gain,
   input wire primary_rf_bias,
   input wire secondary_rf_bias,
   input wire reference_input_bias,
   input wire primary_bandgap_on,
   input wire secondary_bandgap_on,
   input wire primary_lock,
   input wire secondary_lock
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // ------
   // Cycles since primary bandgap came up
   // ------
   reg [7:0] up_cnt;
   always @(posedge clk or posedge rst) begin
      if (rst)
         up_cnt <= 8'h00;
      else if (!primary_bandgap_on)
         up_cnt <= 8'h00;
      else if (up_cnt != 8'hFF)
         up_cnt <= up_cnt + 8'h01;
   end

   sequence s_pri_off;
      !primary_pll_enable [*6];
   endsequence
   sequence s_sec_off;
      !secondary_pll_enable [*6];
   endsequence

   a_pri_down_hold: assert property (
      s_pri_off |-> !primary_lock && !primary_pump_output_oe
         && !primary_bandgap_on && !primary_rf_bias)
      else $error("primary loop still live while disabled");
   a_sec_down_hold: assert property (
      s_sec_off |-> !secondary_lock && !secondary_pump_output_oe
         && !secondary_bandgap_on && !secondary_rf_bias)
      else $error("secondary loop still live while disabled");
   a_ref_bias_off: assert property (
      (!primary_pll_enable && !secondary_pll_enable) [*6]
         |-> !reference_input_bias)
      else $error("reference stage on with both loops down");
   a_ref_bias_on: assert property (
      (primary_pll_enable || secondary_pll_enable) [*6]
         |-> reference_input_bias)
      else $error("reference stage off with a loop enabled");
   a_pri_power_up: assert property (
      $rose(primary_pll_enable)
         |-> ##[1:5] primary_bandgap_on && primary_rf_bias)
      else $error("primary bandgap late after enable");
   a_sec_power_up: assert property (
      $rose(secondary_pll_enable)
         |-> ##[1:5] secondary_bandgap_on && secondary_rf_bias)
      else $error("secondary bandgap late after enable");
   // One cycle of margin for the output flop
   a_pri_active_gap: assert property (
      $rose(primary_lock || primary_pump_output_oe) |-> up_cnt >= 8'd99)
      else $error("primary loop active too soon after power up");
   a_gain_hold: assert property (
      $stable(latch_strobe) [*8]
         |-> $stable(primary_pump_gain) && $stable(secondary_pump_gain))
      else $error("pump gain changed without a latch strobe");
endmodule

//--- tb/dpscb_host.sv
`timescale 1ns/1ns

module dpscb_host (
   input wire clk,
   output reg serial_clock,
   output reg serial_data,
   output reg latch_strobe
);
   integer i;

   initial begin
      serial_clock = 1'b0;
      serial_data = 1'b1;
      latch_strobe = 1'b0;
   end

   // ------
   // One word, 160 ns link clock, idle low between frames
   // ------
   task send(input [17:0] w);
      begin
         for (i = 17; i >= 0; i = i - 1) begin
            // Data moves with the falling link clock: 160 ns a bit
            serial_data <= w[i];
            repeat (8) @(posedge clk);
            serial_clock <= 1'b1;
            repeat (8) @(posedge clk);
            serial_clock <= 1'b0;
         end
         repeat (8) @(posedge clk);
         latch_strobe <= 1'b1;
         repeat (8) @(posedge clk);
         latch_strobe <= 1'b0;
         // Hold time over, so the line no longer shows the last bit
         serial_data <= ~w[0];
      end
   endtask
endmodule

//--- tb/dpscb_config_bank_tb.sv
`timescale 1ns/1ns

module dpscb_config_bank_tb;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg reference_input = 1'b0;
   reg primary_rf_input = 1'b0;
   reg secondary_rf_input = 1'b0;
   reg primary_pll_enable = 1'b0;
   reg secondary_pll_enable = 1'b0;
   reg run_ref = 1'b0;
   reg run_rf = 1'b0;
   reg ph = 1'b0;
   reg pump_seen = 1'b0;
   reg pump_up = 1'b0;
   reg [31:0] seed = 32'h37555415;
   integer fails = 0;
   integer checked = 0;
   integer cycles = 0;
   integer k;
   integer t;
   wire serial_clock, serial_data, latch_strobe, multifunction_output;
   wire primary_pump_gain, secondary_pump_gain, reference_input_bias;
   wire primary_rf_bias, secondary_rf_bias, primary_lock, secondary_lock;
   wire primary_bandgap_on, secondary_bandgap_on;
   wire primary_pump_output, primary_pump_output_oe;

   dpscb_host i_host (.clk(clk), .serial_clock(serial_clock),
      .serial_data(serial_data), .latch_strobe(latch_strobe));

   dpscb_config_bank i_dut (.clk(clk), .rst(rst),
      .serial_clock(serial_clock), .serial_data(serial_data),
      .latch_strobe(latch_strobe), .reference_input(reference_input),
      .primary_rf_input(primary_rf_input),
      .secondary_rf_input(secondary_rf_input),
      .primary_pll_enable(primary_pll_enable),
      .secondary_pll_enable(secondary_pll_enable),
      .multifunction_output(multifunction_output),
      .primary_pump_output(primary_pump_output),
      .primary_pump_output_oe(primary_pump_output_oe),
      .secondary_pump_output(), .secondary_pump_output_oe(),
      .primary_pump_gain(primary_pump_gain),
      .secondary_pump_gain(secondary_pump_gain),
      .primary_rf_bias(primary_rf_bias),
      .secondary_rf_bias(secondary_rf_bias),
      .reference_input_bias(reference_input_bias),
      .primary_bandgap_on(primary_bandgap_on),
      .secondary_bandgap_on(secondary_bandgap_on),
      .primary_lock(primary_lock), .secondary_lock(secondary_lock));

   always #5 clk = ~clk;

   // ------
   // Shared edges keep both dividers in step; a pause slips phase
   // ------
   always @(posedge clk) begin
      ph <= ~ph;
      cycles <= cycles + 1;
      if (run_ref) begin
         reference_input <= ph;
         secondary_rf_input <= seed[0];
      end
      if (run_rf)
         primary_rf_input <= ph;
      // Last direction the primary pump was driven in
      if (primary_pump_output_oe) begin
         pump_seen <= 1'b1;
         pump_up <= primary_pump_output;
      end
      if (cycles == 40000) begin
         fails = fails + 1;
         close_out;
      end
   end

   function [31:0] xs(input [31:0] s);
      reg [31:0] v;
      begin
         v = s ^ (s << 13);
         v = v ^ (v >> 17);
         xs = v ^ (v << 5);
      end
   endfunction

   // Counter sources stay quiet while both loops are down
   function exp_mfo(input [3:0] sel, input pl, input sl);
      begin
         case (sel[3:1])
            3'h0: exp_mfo = sel[0];
            3'h1: exp_mfo = pl;
            3'h2: exp_mfo = sl;
            3'h3: exp_mfo = pl & sl;
            default: exp_mfo = 1'b0;
         endcase
      end
   endfunction

   task check(input string name, input [15:0] seen, input [15:0] exp);
      begin
         checked = checked + 1;
         if (seen !== exp) begin
            fails = fails + 1;
            $display("[FAIL] %0s expected %h seen %h", name, exp, seen);
         end
      end
   endtask

   task put(input [15:0] p, input [1:0] a);
      begin
         i_host.send({p, a});
         repeat (6) @(posedge clk);
      end
   endtask

   task wait_lock(input exp, output integer n);
      begin
         n = 0;
         while (primary_lock !== exp && n < 8000) begin
            @(posedge clk);
            n = n + 1;
         end
      end
   endtask

   task close_out;
      begin
         $display("checked %0d fails %0d", checked, fails);
         if (fails == 0 && checked > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check("mfo_rst", multifunction_output, 0);
      check("gain_rst", {primary_pump_gain, secondary_pump_gain}, 0);
      for (k = 0; k < 16; k = k + 1) begin
         seed = xs(seed);
         put({k[3:0], 12'(seed % 4094 + 2)}, 2'h2);
         check("pri_gain", primary_pump_gain, k[2]);
         check("sec_gain", secondary_pump_gain, k[3]);
      end
      for (k = 0; k < 4; k = k + 1) begin
         // Legal words only: R 2, secondary N 56, primary N 992
         if (k != 2)
            put(k == 0 ? 16'h0002 : k == 1 ? 16'h0070 : 16'h03E0,
               k[1:0]);
         check("gain_keep", {primary_pump_gain, secondary_pump_gain},
            2'h3);
      end
      for (k = 0; k < 16; k = k + 1) begin
         seed = xs(seed);
         put({k[3:0], 12'(seed % 4094 + 2)}, 2'h0);
         check("mfo_sel", multifunction_output,
            exp_mfo(k[3:0], 1'b0, 1'b0));
      end
      secondary_pll_enable <= 1'b1;
      repeat (6) @(posedge clk);
      check("bias_sec", {reference_input_bias, primary_rf_bias,
         secondary_bandgap_on}, 3'h5);
      secondary_pll_enable <= 1'b0;
      repeat (6) @(posedge clk);
      check("bias_off", reference_input_bias, 0);
      put({4'h1, 12'h3E0}, 2'h2);
      put({11'h01F, 5'h00}, 2'h3);
      put({4'h2, 12'h060}, 2'h0);
      for (k = 0; k < 2; k = k + 1) begin
         primary_pll_enable <= 1'b1;
         run_ref <= 1'b1;
         run_rf <= 1'b1;
         wait_lock(1'b1, t);
         check("lock_up", primary_lock, 1);
         // Power-up plus three more comparisons of 1984 cycles
         check("lock_late", t >= 6052, 1);
         @(posedge clk);
         check("mfo_lock", multifunction_output, 1);
         if (k == 0) begin
            primary_pll_enable <= 1'b0;
            run_ref <= 1'b0;
            run_rf <= 1'b0;
            repeat (6) @(posedge clk);
            check("lock_down", {primary_lock, multifunction_output},
               0);
         end
      end
      run_rf <= 1'b0;
      repeat (8) @(posedge clk);
      run_rf <= 1'b1;
      wait_lock(1'b0, t);
      check("lock_lost", primary_lock, 0);
      check("lock_fast", t < 2000, 1);
      // Reference led and polarity is positive, so pump goes up
      check("pump_dir", {pump_seen, pump_up}, 2'h3);
      close_out;
   end
endmodule

bind dpscb_config_bank dpscb_checker i_chk (.clk(clk), .rst(rst),
   .latch_strobe(latch_strobe), .primary_pll_enable(primary_pll_enable),
   .secondary_pll_enable(secondary_pll_enable),
   .primary_pump_output_oe(primary_pump_output_oe),
   .secondary_pump_output_oe(secondary_pump_output_oe),
   .primary_pump_gain(primary_pump_gain),
   .secondary_pump_gain(secondary_pump_gain),
   .primary_rf_bias(primary_rf_bias),
   .secondary_rf_bias(secondary_rf_bias),
   .reference_input_bias(reference_input_bias),
   .primary_bandgap_on(primary_bandgap_on),
   .secondary_bandgap_on(secondary_bandgap_on),
   .primary_lock(primary_lock), .secondary_lock(secondary_lock));
